// >>> rtl/sfrm_top.sv
// Implementation choice: register access over AHB-Lite.
module sfrm_top #(
	parameter bit NARROW_PKG = 1'b0
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic master_clear_n,
	input wire logic watchdog_timeout,
	input wire logic rc_osc_mode,
	output logic [12:0] program_counter,
	output logic instruction_rate_clock_out,
	output sfrm_pkg::sfrm_ctrl_t ctrl
);
	// --------------------------------------------------------------
	// Declarations
	// --------------------------------------------------------------
	sfrm_pkg::sfrm_bus_t state_r;
	sfrm_pkg::sfrm_bus_t state_nxt;
	sfrm_pkg::sfrm_req_t req_r;
	sfrm_pkg::sfrm_tgt_t tgt;
	logic accept;
	logic soft_rst;
	logic wr_en;
	logic pc_low_wr;
	logic ram_we;
	logic [7:0] wdata;
	logic [7:0] rd_val;
	logic [7:0] ram_rdata;
	logic [7:0] hrdata_r;
	logic [31:0][7:0] sfr_r;
	logic [4:0] pc_hi_r;
	logic [4:0] latch_q;
	logic [7:0] pointer_q;
	logic [1:0] div_r;
	logic [1:0] div_nxt;
	logic clkout_r;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// --------------------------------------------------------------
	// Reset requests
	// --------------------------------------------------------------
	// hold in reset
	assign soft_rst = !master_clear_n || watchdog_timeout;

	// --------------------------------------------------------------
	// Bus front end
	// --------------------------------------------------------------
	assign accept = hsel && htrans[1] && hready;
	assign hreadyout = (state_r != sfrm_pkg::SFRM_BUS_RDWAIT);
	assign hresp = 1'b0;
	assign hrdata = {24'h000000, hrdata_r};
	assign wdata = hwdata[7:0];

	always_comb
	begin
		state_nxt = sfrm_pkg::SFRM_BUS_IDLE;
		if (accept)
		begin
			if (hwrite)
				state_nxt = sfrm_pkg::SFRM_BUS_WRITE;
			else
				state_nxt = sfrm_pkg::SFRM_BUS_RDWAIT;
		end
		else if (state_r == sfrm_pkg::SFRM_BUS_RDWAIT)
		begin
			state_nxt = sfrm_pkg::SFRM_BUS_RDDONE;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state_r <= sfrm_pkg::SFRM_BUS_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			req_r <= '0;
		end
		else if (accept)
		begin
			req_r.write <= hwrite;
			req_r.ok <= (haddr[31:11] == 21'h000000) &&
				(hsize == sfrm_pkg::SFRM_HSIZE_WORD);
			req_r.addr <= haddr[10:2];
		end
	end

	// --------------------------------------------------------------
	// Address decode
	// --------------------------------------------------------------
	function automatic sfrm_pkg::sfrm_tgt_t decode(input logic [8:0] a);
		sfrm_pkg::sfrm_tgt_t t;
		logic [6:0] lo;
		logic [7:0] off;
		t = '0;
		lo = a[6:0];
		off = {1'b0, lo} - {1'b0, sfrm_pkg::SFRM_GPR_LO};
		if (lo < sfrm_pkg::SFRM_GPR_LO)
		begin
			if (sfrm_pkg::SFRM_MIRROR[lo[4:0]] ||
				a[8:7] == sfrm_pkg::SFRM_BANK_SFR)
			begin
				t.kind = sfrm_pkg::SFRM_TGT_SFR;
				t.idx = lo[4:0];
			end
		end
		else if (lo >= sfrm_pkg::SFRM_COMMON_LO)
		begin
			t.kind = sfrm_pkg::SFRM_TGT_RAM;
			t.ram = off;
		end
		else if (a[8:7] != sfrm_pkg::SFRM_BANK_NO_RAM)
		begin
			t.kind = sfrm_pkg::SFRM_TGT_RAM;
			t.ram = sfrm_pkg::SFRM_BANK_BASE[a[8:7]] + off;
		end
		return t;
	endfunction

	always_comb
	begin
		tgt = decode(req_r.addr);
		if (!req_r.ok)
		begin
			tgt = '0;
		end
		else if (tgt.kind == sfrm_pkg::SFRM_TGT_SFR &&
			tgt.idx == sfrm_pkg::SFRM_IX_INDIRECT)
		begin
			tgt = decode({sfr_r[sfrm_pkg::SFRM_IX_STATUS][sfrm_pkg::SFRM_IRP_BIT],
				sfr_r[sfrm_pkg::SFRM_IX_POINTER]});
			if (tgt.kind == sfrm_pkg::SFRM_TGT_SFR &&
				tgt.idx == sfrm_pkg::SFRM_IX_INDIRECT)
				tgt = '0;
		end
	end

	assign wr_en = (state_r == sfrm_pkg::SFRM_BUS_WRITE) && !soft_rst;
	assign ram_we = wr_en && tgt.kind == sfrm_pkg::SFRM_TGT_RAM;
	assign pc_low_wr = wr_en && tgt.kind == sfrm_pkg::SFRM_TGT_SFR &&
		tgt.idx == sfrm_pkg::SFRM_IX_PC_LOW;

	// --------------------------------------------------------------
	// Read path
	// --------------------------------------------------------------
	always_comb
	begin
		rd_val = 8'h00;
		unique case (tgt.kind)
			sfrm_pkg::SFRM_TGT_SFR: rd_val = sfr_r[tgt.idx];
			sfrm_pkg::SFRM_TGT_RAM: rd_val = ram_rdata;
			sfrm_pkg::SFRM_TGT_NONE: rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_r <= 8'h00;
		else if (state_r == sfrm_pkg::SFRM_BUS_RDWAIT)
			hrdata_r <= rd_val;
	end

	sfrm_gpr_ram #(
		.AW(8),
		.WIDTH(8)
	) u_ram (
		.hclk(hclk),
		.we(ram_we),
		.addr(tgt.ram),
		.wdata(wdata),
		.rdata(ram_rdata)
	);

	// --------------------------------------------------------------
	// Register file
	// --------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++)
		begin : g_sfr
			localparam sfrm_pkg::sfrm_attr_t A = sfrm_pkg::SFRM_ATTR[gi];
			localparam bit NARROW_GONE = NARROW_PKG &&
				(gi == sfrm_pkg::SFRM_IX_DIR_D ||
				gi == sfrm_pkg::SFRM_IX_DIR_E);
			localparam logic [7:0] IMPL = NARROW_GONE ? 8'h00 : A.impl;
			logic [7:0] val_r;
			logic [7:0] soft_val;

			always_comb
			begin
				soft_val = (val_r & A.keep) | (A.por & ~A.keep);
				if (gi == sfrm_pkg::SFRM_IX_STATUS && watchdog_timeout)
				begin
					soft_val[sfrm_pkg::SFRM_TO_BIT] = 1'b0;
					soft_val[sfrm_pkg::SFRM_PD_BIT] = 1'b1;
				end
			end

			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
					val_r <= A.por & IMPL;
				else if (soft_rst)
					val_r <= soft_val & IMPL;
				else if (wr_en && tgt.kind == sfrm_pkg::SFRM_TGT_SFR &&
					tgt.idx == 5'(gi))
					val_r <= ((val_r & ~A.wmask) | (wdata & A.wmask)) & IMPL;
			end

			assign sfr_r[gi] = val_r;
		end
	endgenerate

	assign latch_q = sfr_r[sfrm_pkg::SFRM_IX_PC_LATCH][4:0];
	assign pointer_q = sfr_r[sfrm_pkg::SFRM_IX_POINTER];

	assign ctrl.option = sfr_r[sfrm_pkg::SFRM_IX_OPTION];
	assign ctrl.dir_a = sfr_r[sfrm_pkg::SFRM_IX_DIR_A];
	assign ctrl.dir_b = sfr_r[sfrm_pkg::SFRM_IX_DIR_B];
	assign ctrl.dir_c = sfr_r[sfrm_pkg::SFRM_IX_DIR_C];
	assign ctrl.dir_d = sfr_r[sfrm_pkg::SFRM_IX_DIR_D];
	assign ctrl.dir_e = sfr_r[sfrm_pkg::SFRM_IX_DIR_E];
	assign ctrl.intctl = sfr_r[sfrm_pkg::SFRM_IX_INTCTL];

	// --------------------------------------------------------------
	// Program counter upper bits
	// --------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pc_hi_r <= 5'h00;
		else if (soft_rst)
			pc_hi_r <= 5'h00;
		else if (pc_low_wr)
			pc_hi_r <= latch_q;
	end

	assign program_counter = {pc_hi_r, sfr_r[sfrm_pkg::SFRM_IX_PC_LOW]};

	// --------------------------------------------------------------
	// Instruction rate clock out
	// --------------------------------------------------------------
	assign div_nxt = div_r + 2'h1;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div_r <= 2'h0;
			clkout_r <= 1'b0;
		end
		else if (soft_rst)
		begin
			div_r <= 2'h0;
			clkout_r <= 1'b0;
		end
		else
		begin
			div_r <= div_nxt;
			clkout_r <= rc_osc_mode && div_nxt[1];
		end
	end

	assign instruction_rate_clock_out = clkout_r;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	sequence s_pc_low_write;
		pc_low_wr;
	endsequence

	sequence s_pointer_write;
		state_r == sfrm_pkg::SFRM_BUS_WRITE && req_r.ok && !soft_rst &&
			req_r.addr[6:0] == {2'b00, sfrm_pkg::SFRM_IX_POINTER};
	endsequence

	sequence s_unimpl_read;
		state_r == sfrm_pkg::SFRM_BUS_RDWAIT &&
			tgt.kind == sfrm_pkg::SFRM_TGT_NONE;
	endsequence

	sequence s_clear_held;
		!master_clear_n [*3];
	endsequence

	sequence s_rc_run;
		rc_osc_mode && !soft_rst;
	endsequence

	sequence s_ind_read;
		state_r == sfrm_pkg::SFRM_BUS_RDWAIT && req_r.ok &&
			req_r.addr[6:0] == {2'b00, sfrm_pkg::SFRM_IX_INDIRECT} &&
			tgt.kind == sfrm_pkg::SFRM_TGT_RAM;
	endsequence

	chk_pc_upper_copy: assert property (
		s_pc_low_write |=> pc_hi_r == $past(latch_q))
	else
		$error("upper counter bits not loaded from latch");

	chk_pc_upper_hold: assert property (
		!pc_low_wr && !soft_rst |=> $stable(pc_hi_r))
	else
		$error("upper counter bits changed without low byte write");

	chk_mirror_pointer: assert property (
		s_pointer_write |=> pointer_q == $past(wdata))
	else
		$error("pointer write in some bank missed the shared register");

	chk_unimpl_read_zero: assert property (
		s_unimpl_read |=> hrdata_r == 8'h00 && hreadyout)
	else
		$error("unimplemented location did not read zero");

	chk_soft_reset_vals: assert property (
		soft_rst |=> sfr_r[sfrm_pkg::SFRM_IX_OPTION] ==
			sfrm_pkg::SFRM_ATTR[sfrm_pkg::SFRM_IX_OPTION].por &&
			sfr_r[sfrm_pkg::SFRM_IX_PC_LATCH] == 8'h00)
	else
		$error("non-power-up reset value not loaded");

	chk_keep_pointer: assert property (
		soft_rst |=> pointer_q == $past(pointer_q))
	else
		$error("pointer lost its value over non-power-up reset");

	chk_narrow_ports: assert property (
		NARROW_PKG |-> sfr_r[sfrm_pkg::SFRM_IX_DIR_D] == 8'h00 &&
			sfr_r[sfrm_pkg::SFRM_IX_DIR_E] == 8'h00)
	else
		$error("absent port direction register is not zero");

	chk_clear_hold: assert property (
		s_clear_held |-> pc_hi_r == 5'h00 &&
			sfr_r[sfrm_pkg::SFRM_IX_PC_LOW] == 8'h00 && !clkout_r)
	else
		$error("logic not held in reset under master clear");

	chk_clkout_quarter: assert property (
		s_rc_run [*2] ##1 $rose(clkout_r) ##0 s_rc_run [*5] |-> $rose(clkout_r) &&
			!$past(clkout_r, 2) && $past(clkout_r, 3))
	else
		$error("clock out period is not four input clocks");

	chk_indirect_read: assert property (
		s_ind_read |=> hrdata_r == $past(ram_rdata))
	else
		$error("indirect read did not return the pointed byte");
endmodule

// >>> inc/sfrm_pkg.sv
package sfrm_pkg;
	// --------------------------------------------------------------
	// Register addresses and indices (byte address is four times the register address)
	// --------------------------------------------------------------
	localparam logic [7:0] SFRM_INDIRECT_ACCESS_PORT = 8'h80;
	localparam logic [7:0] SFRM_OPTION_CONTROL = 8'h81;
	localparam logic [7:0] SFRM_PROGRAM_COUNTER_LOW = 8'h82;
	localparam logic [7:0] SFRM_CORE_STATUS_FLAGS = 8'h83;
	localparam logic [7:0] SFRM_INDIRECT_POINTER = 8'h84;
	localparam logic [7:0] SFRM_PORT_A_DIRECTION = 8'h85;
	localparam logic [7:0] SFRM_PORT_B_DIRECTION = 8'h86;
	localparam logic [7:0] SFRM_PORT_C_DIRECTION = 8'h87;
	localparam logic [7:0] SFRM_PORT_D_DIRECTION = 8'h88;
	localparam logic [7:0] SFRM_PORT_E_DIR_SLAVE_STATUS = 8'h89;
	localparam logic [7:0] SFRM_PC_UPPER_LATCH = 8'h8A;
	localparam logic [7:0] SFRM_INTERRUPT_CONTROL = 8'h8B;
	localparam logic [7:0] SFRM_PERIPHERAL_IRQ_ENABLE_ONE = 8'h8C;
	localparam logic [7:0] SFRM_PERIPHERAL_IRQ_ENABLE_TWO = 8'h8D;
	localparam logic [7:0] SFRM_POWER_RESET_CAUSE = 8'h8E;
	localparam logic [7:0] SFRM_SERIAL_PORT_CONTROL_TWO = 8'h91;
	localparam logic [7:0] SFRM_TIMER_TWO_PERIOD = 8'h92;
	localparam logic [7:0] SFRM_SERIAL_PORT_ADDRESS_OR_RATE = 8'h93;
	localparam logic [7:0] SFRM_SERIAL_PORT_STATE = 8'h94;
	localparam logic [7:0] SFRM_UART_TRANSMIT_CONTROL = 8'h98;
	localparam logic [7:0] SFRM_UART_RATE_DIVISOR = 8'h99;
	localparam logic [7:0] SFRM_VOLTAGE_REFERENCE_CONTROL = 8'h9B;
	localparam logic [7:0] SFRM_LOW_VOLTAGE_DETECT_CONTROL = 8'h9C;
	localparam logic [7:0] SFRM_CONVERTER_RESULT_LOW = 8'h9E;
	localparam logic [7:0] SFRM_CONVERTER_CONTROL_ONE = 8'h9F;

	localparam logic [4:0] SFRM_IX_INDIRECT = SFRM_INDIRECT_ACCESS_PORT[4:0];
	localparam logic [4:0] SFRM_IX_OPTION = SFRM_OPTION_CONTROL[4:0];
	localparam logic [4:0] SFRM_IX_PC_LOW = SFRM_PROGRAM_COUNTER_LOW[4:0];
	localparam logic [4:0] SFRM_IX_STATUS = SFRM_CORE_STATUS_FLAGS[4:0];
	localparam logic [4:0] SFRM_IX_POINTER = SFRM_INDIRECT_POINTER[4:0];
	localparam logic [4:0] SFRM_IX_DIR_A = SFRM_PORT_A_DIRECTION[4:0];
	localparam logic [4:0] SFRM_IX_DIR_B = SFRM_PORT_B_DIRECTION[4:0];
	localparam logic [4:0] SFRM_IX_DIR_C = SFRM_PORT_C_DIRECTION[4:0];
	localparam logic [4:0] SFRM_IX_DIR_D = SFRM_PORT_D_DIRECTION[4:0];
	localparam logic [4:0] SFRM_IX_DIR_E = SFRM_PORT_E_DIR_SLAVE_STATUS[4:0];
	localparam logic [4:0] SFRM_IX_PC_LATCH = SFRM_PC_UPPER_LATCH[4:0];
	localparam logic [4:0] SFRM_IX_INTCTL = SFRM_INTERRUPT_CONTROL[4:0];

	// --------------------------------------------------------------
	// Map layout
	// --------------------------------------------------------------
	localparam logic [31:0] SFRM_MIRROR = 32'h00000C1D;
	localparam logic [1:0] SFRM_BANK_SFR = 2'h1;
	localparam logic [1:0] SFRM_BANK_NO_RAM = 2'h3;
	localparam logic [6:0] SFRM_GPR_LO = 7'h20;
	localparam logic [6:0] SFRM_COMMON_LO = 7'h70;
	localparam logic [7:0] SFRM_BANK_BASE [4] = '{8'h00, 8'h60, 8'hB0, 8'h00};
	localparam int SFRM_IRP_BIT = 7;
	localparam int SFRM_TO_BIT = 4;
	localparam int SFRM_PD_BIT = 3;
	localparam logic [2:0] SFRM_HSIZE_WORD = 3'h2;
	localparam int SFRM_CLKOUT_RATIO = 4;

	// --------------------------------------------------------------
	// Per register: implemented, writable, power-up, kept bits
	// --------------------------------------------------------------
	typedef struct packed {
		logic [7:0] impl;
		logic [7:0] wmask;
		logic [7:0] por;
		logic [7:0] keep;
	} sfrm_attr_t;

	localparam sfrm_attr_t SFRM_ATTR [32] = '{
		'{8'h00, 8'h00, 8'h00, 8'h00}, '{8'hFF, 8'hFF, 8'hFF, 8'h00},
		'{8'hFF, 8'hFF, 8'h00, 8'h00}, '{8'hFF, 8'hE7, 8'h18, 8'h1F},
		'{8'hFF, 8'hFF, 8'h00, 8'hFF}, '{8'h3F, 8'h3F, 8'h3F, 8'h00},
		'{8'hFF, 8'hFF, 8'hFF, 8'h00}, '{8'hFF, 8'hFF, 8'hFF, 8'h00},
		'{8'hFF, 8'hFF, 8'hFF, 8'h00}, '{8'hF7, 8'h17, 8'h07, 8'h00},
		'{8'h1F, 8'h1F, 8'h00, 8'h00}, '{8'hFF, 8'hFF, 8'h00, 8'h01},
		'{8'hFF, 8'hFF, 8'h00, 8'h00}, '{8'h89, 8'h89, 8'h00, 8'h00},
		'{8'h03, 8'h03, 8'h00, 8'h03}, '{8'h00, 8'h00, 8'h00, 8'h00},
		'{8'h00, 8'h00, 8'h00, 8'h00}, '{8'hFF, 8'hBF, 8'h00, 8'h00},
		'{8'hFF, 8'hFF, 8'hFF, 8'h00}, '{8'hFF, 8'hFF, 8'h00, 8'h00},
		'{8'hFF, 8'hC0, 8'h00, 8'h00}, '{8'h00, 8'h00, 8'h00, 8'h00},
		'{8'h00, 8'h00, 8'h00, 8'h00}, '{8'h00, 8'h00, 8'h00, 8'h00},
		'{8'hF7, 8'hF5, 8'h02, 8'h00}, '{8'hFF, 8'hFF, 8'h00, 8'h00},
		'{8'h00, 8'h00, 8'h00, 8'h00}, '{8'hF0, 8'hF0, 8'h00, 8'h00},
		'{8'h3F, 8'h1F, 8'h05, 8'h00}, '{8'h00, 8'h00, 8'h00, 8'h00},
		'{8'hFF, 8'hFF, 8'h00, 8'hFF}, '{8'hFF, 8'hFF, 8'h00, 8'h00}
	};

	typedef enum logic [1:0] {
		SFRM_TGT_NONE,
		SFRM_TGT_SFR,
		SFRM_TGT_RAM
	} sfrm_kind_t;

	typedef struct packed {
		sfrm_kind_t kind;
		logic [4:0] idx;
		logic [7:0] ram;
	} sfrm_tgt_t;

	typedef struct packed {
		logic write;
		logic ok;
		logic [8:0] addr;
	} sfrm_req_t;

	typedef struct packed {
		logic [7:0] option;
		logic [7:0] dir_a;
		logic [7:0] dir_b;
		logic [7:0] dir_c;
		logic [7:0] dir_d;
		logic [7:0] dir_e;
		logic [7:0] intctl;
	} sfrm_ctrl_t;

	typedef enum logic [1:0] {
		SFRM_BUS_IDLE,
		SFRM_BUS_WRITE,
		SFRM_BUS_RDWAIT,
		SFRM_BUS_RDDONE
	} sfrm_bus_t;
endpackage

// >>> rtl/sfrm_gpr_ram.sv
module sfrm_gpr_ram #(
	parameter int AW = 8,
	parameter int WIDTH = 8
) (
	input wire logic hclk,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] rdata
);
	// --------------------------------------------------------------
	// General purpose storage
	// --------------------------------------------------------------
	logic [WIDTH-1:0] mem [1 << AW];

	always_ff @(posedge hclk)
	begin
		if (we)
			mem[addr] <= wdata;
	end

	assign rdata = mem[addr];
endmodule

// >>> verification/sfrm_core_model.sv
// ------------------------------------------
// Core datapath bus master
// ------------------------------------------
module sfrm_core_model #(
	parameter bit NARROW_PKG = 1'b0
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic req,
	input wire logic req_wr,
	input wire logic [8:0] req_addr,
	input wire logic [7:0] req_wdata,
	output logic done,
	output logic was_rd,
	output logic [31:0] rdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] st_r;
	logic [7:0] wd_r;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_r <= 2'h0;
			wd_r <= 8'h00;
			hsel <= 1'b0;
			haddr <= 32'h00000000;
			htrans <= 2'h0;
			hwrite <= 1'b0;
			hsize <= 3'h2;
			hwdata <= 32'h00000000;
			done <= 1'b0;
			was_rd <= 1'b0;
			rdata <= 32'h00000000;
		end
		else
		begin
			done <= 1'b0;
			case (st_r)
				2'h0: if (req)
				begin
					hsel <= 1'b1;
					htrans <= 2'h2;
					haddr <= {21'h000000, req_addr, 2'h0};
					hwrite <= req_wr;
					wd_r <= req_wdata;
					if (NARROW_PKG && req_addr[6:0] == 7'h0C)
						wd_r <= req_wdata & 8'h7F;
					st_r <= 2'h1;
				end
				2'h1: if (hready)
				begin
					htrans <= 2'h0;
					haddr <= ~haddr;
					hwdata <= {24'h000000, wd_r};
					st_r <= 2'h2;
				end
				default: if (hready)
				begin
					rdata <= hrdata;
					was_rd <= !hwrite;
					done <= 1'b1;
					hsel <= 1'b0;
					hwdata <= ~hwdata;
					st_r <= 2'h0;
				end
			endcase
		end
	end
endmodule

// >>> verification/sfrm_top_tb.sv
// ------------------------------------------
// Register map bench
// ------------------------------------------
module sfrm_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'b0;
	logic hresetn;
	logic master_clear_n = 1'b1;
	logic watchdog_timeout = 1'b0;
	logic rc_osc_mode = 1'b0;
	logic req = 1'b0;
	logic req_wr = 1'b0;
	logic [8:0] req_addr = 9'h000;
	logic [7:0] req_wdata = 8'h00;
	logic [7:0] lfsr_r = 8'h37;
	logic hsel, hwrite, hready, hresp, done, was_rd, clk_out;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rdata;
	logic [12:0] program_counter;
	sfrm_pkg::sfrm_ctrl_t ctrl;
	logic [31:0] exp_q [$];
	int n_fail = 0;
	int cmp_count = 0;
	logic [8:0] pa [16] = '{9'h081, 9'h082, 9'h083, 9'h085, 9'h086,
		9'h087, 9'h088, 9'h089, 9'h08A, 9'h08B, 9'h08C, 9'h092,
		9'h098, 9'h09C, 9'h08F, 9'h095};
	logic [7:0] pv [16] = '{8'hFF, 8'h00, 8'h18, 8'h3F, 8'hFF,
		8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
		8'h02, 8'h05, 8'h00, 8'h00};
	always #2 hclk = ~hclk;
	sfrm_core_model #(.NARROW_PKG(1'b1)) core_u (.hclk(hclk),
		.hresetn(hresetn), .req(req), .req_wr(req_wr),
		.req_addr(req_addr), .req_wdata(req_wdata), .done(done),
		.was_rd(was_rd), .rdata(rdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata));
	sfrm_top #(.NARROW_PKG(1'b1)) dut_u (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp),
		.master_clear_n(master_clear_n),
		.watchdog_timeout(watchdog_timeout),
		.rc_osc_mode(rc_osc_mode), .program_counter(program_counter),
		.instruction_rate_clock_out(clk_out), .ctrl(ctrl));
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic results;
		if (exp_q.size() != 0)
			n_fail++;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [8:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge hclk);
		req <= 1'b1;
		req_wr <= w;
		req_addr <= a;
		req_wdata <= d;
		@(posedge hclk);
		req <= 1'b0;
		do
		begin
			@(negedge hclk);
			n++;
		end
		while (done !== 1'b1 && n < 50);
		if (n >= 50)
			n_fail++;
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [8:0] a, input logic [7:0] e);
		exp_q.push_back({24'h000000, e});
		bus(1'b0, a, 8'h00);
	endtask
	task automatic clk_chk(input logic m);
		logic [7:0] p;
		logic ok;
		@(posedge hclk);
		rc_osc_mode <= m;
		repeat (2) @(posedge hclk);
		repeat (8)
		begin
			@(negedge hclk);
			p = {p[6:0], clk_out};
		end
		ok = m ? p inside {8'h33, 8'h66, 8'hCC, 8'h99} : p === 8'h00;
		cmp({31'h0, ok}, 32'h1);
	endtask
	always @(negedge hclk)
		if (done === 1'b1)
		begin
			cmp({31'h0, hresp}, 32'h0);
			if (was_rd === 1'b1 && exp_q.size() > 0)
				cmp(rdata, exp_q.pop_front());
			else if (was_rd === 1'b1)
				n_fail++;
		end
	initial
	begin
		#20000;
		n_fail++;
		results;
	end
	initial
	begin
		hresetn = 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 16; i++)
			rd(pa[i], pv[i]);
		$display("test power_up done");
		wr(9'h085, 8'hFF);
		rd(9'h085, 8'h3F);
		wr(9'h088, 8'hFF);
		rd(9'h088, 8'h00);
		wr(9'h00A, 8'hFF);
		rd(9'h10A, 8'h1F);
		wr(9'h182, 8'h34);
		cmp({19'h0, program_counter}, 32'h00001F34);
		rd(9'h082, 8'h34);
		wr(9'h1A0, 8'h55);
		rd(9'h1A0, 8'h00);
		$display("test mirror_latch done");
		wr(9'h084, 8'h30);
		wr(9'h080, 8'h5A);
		rd(9'h030, 8'h5A);
		for (int i = 0; i < 4; i++)
		begin
			lfsr_r = lfsr(lfsr_r);
			wr(9'(160 + i), lfsr_r);
			wr(9'h184, 8'(160 + i));
			rd(9'h080, lfsr_r);
		end
		$display("test indirect done");
		wr(9'h08C, 8'hFF);
		rd(9'h08C, 8'h7F);
		wr(9'h083, 8'hE7);
		rd(9'h083, 8'hFF);
		wr(9'h081, 8'h00);
		wr(9'h08B, 8'h81);
		@(posedge hclk);
		master_clear_n <= 1'b0;
		wr(9'h081, 8'h00);
		rd(9'h081, 8'hFF);
		@(posedge hclk);
		master_clear_n <= 1'b1;
		rd(9'h083, 8'h1F);
		rd(9'h084, 8'hA3);
		rd(9'h08B, 8'h01);
		rd(9'h08A, 8'h00);
		cmp({19'h0, program_counter}, 32'h0);
		cmp({24'h0, ctrl.option}, 32'hFF);
		cmp({ctrl.dir_a, ctrl.dir_b, ctrl.dir_c, ctrl.intctl}, 32'h3FFFFF01);
		cmp({16'h0, ctrl.dir_d, ctrl.dir_e}, 32'h0);
		@(posedge hclk);
		watchdog_timeout <= 1'b1;
		@(posedge hclk);
		watchdog_timeout <= 1'b0;
		rd(9'h083, 8'h0F);
		wr(9'h084, 8'h00);
		rd(9'h080, 8'h00);
		$display("test soft_reset done");
		clk_chk(1'b1);
		clk_chk(1'b0);
		$display("test clock_out done");
		results;
	end
endmodule
